// ---- bench/cvt_regs_tb.sv ----
// Testbench: AXI4-Lite access to the calibration vector port and trim registers
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import cvt_pkg::*;
	localparam int NV = CVT_VEC_LEN;
	logic        aclk, aresetn;
	logic [11:0] awaddr, araddr;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, rs;
	cvt_trim_t   ftrim, trim;
	logic        halted, cal_en, vwr;
	logic [9:0]  idx;
	logic [7:0]  vwdata, vrdata;
	logic [7:0]  got_q[$];
	logic [11:0] ti[4] = '{CVT_OFS_GAIN_A, CVT_OFS_GAIN_B, CVT_OFS_REF_ADJ, CVT_OFS_TERM_A};
	logic [7:0]  fv[4] = '{8'h5a, 8'ha5, 8'h09, 8'h3c};
	logic [7:0]  tv[4] = '{8'hc1, 8'h1e, 8'hf6, 8'h81};
	logic [7:0]  tm[4] = '{8'hff, 8'hff, 8'h0f, 8'hff};
	int          errors, checked, cycles;

	cvt_regs uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .factory_trim(ftrim), .calibration_halted(halted),
		.trim_out(trim), .cal_en_out(cal_en), .cal_index(idx), .cal_vec_wr(vwr),
		.cal_vec_wdata(vwdata), .cal_vec_rdata(vrdata));

	////////////////////////////////////////////////////////////////////////////////
	// Calibration store stand-in: known pattern per byte index
	assign vrdata = idx[7:0] ^ 8'h33;

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			errors = errors + 1;
			finish_test();
		end
		if (vwr === 1'b1)
			got_q.push_back(vwdata);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Printed offsets are word indices, so byte address is four times them
	function automatic logic [11:0] ba(input logic [11:0] i);
		return {i[9:0], 2'b00};
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [11:0] i, input logic [31:0] d);
		logic aw_ok, w_ok;
		@(posedge aclk);
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= ba(i);
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge aclk);
		rs = bresp;
		bready <= 1'b0;
	endtask

	task automatic rdreg(input logic [11:0] i);
		@(posedge aclk);
		araddr <= ba(i);
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge aclk);
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic finish_test();
		$display("Comparisons %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata, wstrb} = '0;
		aresetn = 1'b0;
		halted = 1'b1;
		ftrim = '{8'h5a, 8'ha5, 4'h9, 8'h3c};
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rdreg(CVT_OFS_CAL_EN);
		chk(rd, {24'h0, CVT_RST_CAL_EN});
		chk({4'h0, trim}, {4'h0, ftrim});
		for (int k = 0; k < 4; k++) begin
			rdreg(ti[k]);
			chk(rd & {24'h0, tm[k]}, {24'h0, fv[k]});
			wr(ti[k], {24'h0, tv[k]});
			chk({30'h0, rs}, {30'h0, CVT_RESP_OKAY});
			rdreg(ti[k]);
			chk(rd & {24'h0, tm[k]}, {24'h0, tv[k] & tm[k]});
		end
		chk({4'h0, trim}, {4'h0, 8'hc1, 8'h1e, 4'h6, 8'h81});
		// Unmapped index between the port and the trims
		wr(12'h075, 32'h0000_00aa);
		chk({30'h0, rs}, {30'h0, CVT_RESP_SLVERR});
		rdreg(12'h075);
		chk(rd, 32'h0);
		chk({30'h0, rs}, {30'h0, CVT_RESP_SLVERR});
		// Port closed: nothing may reach the store
		wr(CVT_OFS_CAL_PORT, 32'h0000_0077);
		repeat (3) @(posedge aclk);
		chk(32'(got_q.size()), 32'h0);
		wr(CVT_OFS_CAL_EN, 32'h1);
		rdreg(CVT_OFS_CAL_EN);
		chk(rd & 32'h1, 32'h1);
		chk({21'h0, idx, cal_en}, {21'h0, 10'h000, 1'b1});
		// Back-to-back streaming readout of the whole vector
		for (int i = 0; i < NV; i++) begin
			rdreg(CVT_OFS_CAL_PORT);
			chk(rd & 32'hff, {24'h0, i[7:0] ^ 8'h33});
		end
		chk({22'h0, idx}, 32'h0);
		for (int i = 0; i < 5; i++)
			rdreg(CVT_OFS_CAL_PORT);
		chk({22'h0, idx}, 32'h5);
		// Aborted readout: re-enabling must restart at the first byte
		wr(CVT_OFS_CAL_EN, 32'h0);
		wr(CVT_OFS_CAL_EN, 32'h1);
		chk({22'h0, idx}, 32'h0);
		got_q.delete();
		for (int i = 0; i < NV; i++)
			wr(CVT_OFS_CAL_PORT, {24'h0, 8'(i * 7)});
		repeat (3) @(posedge aclk);
		chk(32'(got_q.size()), NV);
		for (int i = 0; i < NV && i < got_q.size(); i++)
			chk({24'h0, got_q[i]}, {24'h0, 8'(i * 7)});
		chk({22'h0, idx}, 32'h0);
		rdreg(CVT_OFS_STATUS);
		chk(rd, 32'h0000_0400);
		finish_test();
	end
endmodule
`default_nettype wire

// ---- src/cvt_pkg.sv ----
// Package: register map, reset values and bus types for the calibration/trim register slice
// How it works
// - Enable bit gates calibration vector port
// - Each read returns next vector byte
// - Each write loads next vector element
// - Partial transfer leaves calibration invalid
// - Channel A gain adjust byte
// - Channel B gain adjust byte
// - Trims load factory values after reset
// - Reference adjust low nibble, upper reserved
// - Channel A termination adjust byte
package cvt_pkg;
	localparam logic [11:0] CVT_OFS_CAL_EN   = 12'h070;
	localparam logic [11:0] CVT_OFS_CAL_PORT = 12'h071;
	localparam logic [11:0] CVT_OFS_GAIN_A   = 12'h07a;
	localparam logic [11:0] CVT_OFS_GAIN_B   = 12'h07b;
	localparam logic [11:0] CVT_OFS_REF_ADJ  = 12'h07c;
	localparam logic [11:0] CVT_OFS_TERM_A   = 12'h07e;
	localparam logic [11:0] CVT_OFS_STATUS   = 12'h080;
	localparam int          CVT_VEC_LEN      = 673;
	localparam int          CVT_IDX_W        = 10;
	localparam logic [9:0]  CVT_IDX_LAST     = 10'h2a0;
	localparam int          CVT_EN_BIT       = 0;
	localparam int          CVT_REF_MSB      = 3;
	localparam logic [7:0]  CVT_RST_CAL_EN   = 8'h00;
	localparam logic [7:0]  CVT_RST_TRIM     = 8'h00;
	localparam logic [1:0]  CVT_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  CVT_RESP_SLVERR  = 2'h2;
	typedef struct packed {
		logic [7:0] gain_a;
		logic [7:0] gain_b;
		logic [3:0] ref_adj;
		logic [7:0] term_a;
	} cvt_trim_t;
	typedef enum logic [1:0] {
		CVT_IDLE  = 2'b00,
		CVT_WRESP = 2'b01,
		CVT_RRESP = 2'b10
	} cvt_state_t;
endpackage

// ---- src/cvt_regs.sv ----
// Calibration vector port and factory trim registers behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module cvt_regs
	import cvt_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire cvt_trim_t   factory_trim,
	input  wire logic        calibration_halted,
	output cvt_trim_t        trim_out,
	output logic             cal_en_out,
	output logic [9:0]       cal_index,
	output logic             cal_vec_wr,
	output logic [7:0]       cal_vec_wdata,
	input  wire logic [7:0]  cal_vec_rdata
);
	////////////////////////////////////////////////////////////////////////////
	// Write path: both address and data held until both present
	logic       aw_hold_reg, aw_hold_next;
	logic       w_hold_reg, w_hold_next;
	logic [11:0] awaddr_reg, awaddr_next;
	logic [31:0] wdata_reg, wdata_next;
	logic        bvalid_reg, bvalid_next;
	logic [1:0]  bresp_reg, bresp_next;
	logic        rvalid_reg, rvalid_next;
	logic [1:0]  rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic        cal_en_reg, cal_en_next;
	cvt_trim_t   trim_reg, trim_next;
	logic [9:0]  idx_reg, idx_next;
	logic        loaded_reg, loaded_next;
	logic        partial_reg, partial_next;
	logic        vec_wr_reg, vec_wr_next;
	logic [7:0]  vec_wd_reg, vec_wd_next;
	logic        do_write, do_read, wr_hit, rd_hit, port_acc;
	logic [9:0]  rd_index, wr_index;

	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;
	assign trim_out      = trim_reg;
	assign cal_en_out    = cal_en_reg;
	assign cal_index     = idx_reg;
	assign cal_vec_wr    = vec_wr_reg;
	assign cal_vec_wdata = vec_wd_reg;

	always_comb begin
		aw_hold_next = aw_hold_reg;
		w_hold_next  = w_hold_reg;
		awaddr_next  = awaddr_reg;
		wdata_next   = wdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_next = 1'b1;
			awaddr_next  = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_next = 1'b1;
			wdata_next  = s_axi_wdata;
		end
		do_write = aw_hold_reg && w_hold_reg;
		if (do_write) begin
			aw_hold_next = 1'b0;
			w_hold_next  = 1'b0;
		end
		do_read = s_axi_arvalid && s_axi_arready;
		// Printed offsets are word indices: byte address is four times them
		rd_index = s_axi_araddr[11:2];
		wr_index = awaddr_reg[11:2];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file, vector index and responses
	always_comb begin
		cal_en_next  = cal_en_reg;
		trim_next    = trim_reg;
		idx_next     = idx_reg;
		loaded_next  = loaded_reg;
		partial_next = partial_reg;
		vec_wr_next  = 1'b0;
		vec_wd_next  = vec_wd_reg;
		bvalid_next  = bvalid_reg && !s_axi_bready;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg && !s_axi_rready;
		rresp_next   = rresp_reg;
		rdata_next   = rdata_reg;
		wr_hit       = 1'b1;
		rd_hit       = 1'b1;
		port_acc     = 1'b0;
		// Factory values captured in the first clocked cycle after reset
		if (!loaded_reg) begin
			trim_next   = factory_trim;
			loaded_next = 1'b1;
		end
		if (do_write) begin
			bvalid_next = 1'b1;
			if (s_axi_wstrb[0]) begin
				case (wr_index)
					CVT_OFS_CAL_EN[9:0]: begin
						cal_en_next = wdata_reg[CVT_EN_BIT];
						if (wdata_reg[CVT_EN_BIT] && !cal_en_reg) begin
							idx_next = '0;
						end
					end
					CVT_OFS_CAL_PORT[9:0]: begin
						if (cal_en_reg) begin
							vec_wr_next = 1'b1;
							vec_wd_next = wdata_reg[7:0];
							port_acc    = 1'b1;
						end
					end
					CVT_OFS_GAIN_A[9:0]: trim_next.gain_a = wdata_reg[7:0];
					CVT_OFS_GAIN_B[9:0]: trim_next.gain_b = wdata_reg[7:0];
					CVT_OFS_REF_ADJ[9:0]: trim_next.ref_adj = wdata_reg[CVT_REF_MSB:0];
					CVT_OFS_TERM_A[9:0]: trim_next.term_a = wdata_reg[7:0];
					default: wr_hit = 1'b0;
				endcase
			end
			if (!wr_hit) begin
				bresp_next = CVT_RESP_SLVERR;
			end else begin
				bresp_next = CVT_RESP_OKAY;
			end
		end
		if (do_read) begin
			rvalid_next = 1'b1;
			rresp_next  = CVT_RESP_OKAY;
			rdata_next  = '0;
			case (rd_index)
				CVT_OFS_CAL_EN[9:0]: rdata_next[CVT_EN_BIT] = cal_en_reg;
				CVT_OFS_CAL_PORT[9:0]: begin
					if (cal_en_reg) begin
						rdata_next[7:0] = cal_vec_rdata;
						port_acc = 1'b1;
					end
				end
				CVT_OFS_GAIN_A[9:0]: rdata_next[7:0] = trim_reg.gain_a;
				CVT_OFS_GAIN_B[9:0]: rdata_next[7:0] = trim_reg.gain_b;
				CVT_OFS_REF_ADJ[9:0]: rdata_next[CVT_REF_MSB:0] = trim_reg.ref_adj;
				CVT_OFS_TERM_A[9:0]: rdata_next[7:0] = trim_reg.term_a;
				CVT_OFS_STATUS[9:0]: rdata_next[11:0] = {partial_reg, calibration_halted, idx_reg};
				default: begin
					rd_hit     = 1'b0;
					rresp_next = CVT_RESP_SLVERR;
				end
			endcase
		end
		// Read and write never hit the port together in practice; together they advance one step
		if (port_acc) begin
			if (idx_reg == CVT_IDX_LAST) begin
				idx_next     = '0;
				partial_next = 1'b0;
			end else begin
				idx_next     = idx_reg + 10'h001;
				partial_next = 1'b1;
			end
		end
		if (do_write && wr_index == CVT_OFS_CAL_EN[9:0]
			&& s_axi_wstrb[0] && wdata_reg[CVT_EN_BIT] && !cal_en_reg) begin
			partial_next = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg  <= 1'b0;
			awaddr_reg  <= '0;
			wdata_reg   <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= CVT_RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= CVT_RESP_OKAY;
			rdata_reg   <= '0;
			cal_en_reg  <= CVT_RST_CAL_EN[0];
			trim_reg    <= '{CVT_RST_TRIM, CVT_RST_TRIM, CVT_RST_TRIM[3:0], CVT_RST_TRIM};
			idx_reg     <= '0;
			loaded_reg  <= 1'b0;
			partial_reg <= 1'b0;
			vec_wr_reg  <= 1'b0;
			vec_wd_reg  <= '0;
		end else begin
			aw_hold_reg <= aw_hold_next;
			w_hold_reg  <= w_hold_next;
			awaddr_reg  <= awaddr_next;
			wdata_reg   <= wdata_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			cal_en_reg  <= cal_en_next;
			trim_reg    <= trim_next;
			idx_reg     <= idx_next;
			loaded_reg  <= loaded_next;
			partial_reg <= partial_next;
			vec_wr_reg  <= vec_wr_next;
			vec_wd_reg  <= vec_wd_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	chk_port_gated: assert property (@(posedge aclk) disable iff (!aresetn)
		(!cal_en_reg) |=> !vec_wr_reg)
		else $error("vector write while port disabled");
	chk_idx_advance: assert property (@(posedge aclk) disable iff (!aresetn)
		(vec_wr_next && idx_reg != CVT_IDX_LAST) |=> idx_reg == $past(idx_reg) + 10'h001)
		else $error("index did not advance");
	chk_idx_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		(vec_wr_next && idx_reg == CVT_IDX_LAST) |=> idx_reg == 10'h000 && !partial_reg)
		else $error("index did not wrap after last element");
	chk_gain_a_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		(loaded_reg && do_write && s_axi_wstrb[0] && wr_index == CVT_OFS_GAIN_A[9:0])
		|=> trim_out.gain_a == $past(wdata_reg[7:0]))
		else $error("gain a not written");
	chk_gain_b_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		(loaded_reg && do_write && s_axi_wstrb[0] && wr_index == CVT_OFS_GAIN_B[9:0])
		|=> trim_out.gain_b == $past(wdata_reg[7:0]))
		else $error("gain b not written");
	chk_factory_load: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(loaded_reg) |-> trim_reg == $past(factory_trim))
		else $error("factory trim not loaded");
	chk_ref_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(do_read && rd_index == CVT_OFS_REF_ADJ[9:0]) |=> rvalid_reg && s_axi_rdata[31:4] == 28'h0)
		else $error("reserved reference bits not zero");
	chk_term_wr: assert property (@(posedge aclk) disable iff (!aresetn)
		(loaded_reg && do_write && s_axi_wstrb[0] && wr_index == CVT_OFS_TERM_A[9:0])
		|=> trim_out.term_a == $past(wdata_reg[7:0]))
		else $error("termination a not written");
	chk_idx_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(cal_en_reg) |-> idx_reg == 10'h000)
		else $error("index not restarted on enable");
	chk_partial_flag: assert property (@(posedge aclk) disable iff (!aresetn)
		(port_acc && idx_reg != CVT_IDX_LAST) |=> partial_reg)
		else $error("partial flag not set mid transfer");
	chk_bresp_time: assert property (@(posedge aclk) disable iff (!aresetn)
		do_write |=> bvalid_reg)
		else $error("write response late");
	cov_vec_write: cover property (@(posedge aclk) disable iff (!aresetn) vec_wr_reg);
	cov_vec_wrap: cover property (@(posedge aclk) disable iff (!aresetn)
		port_acc && idx_reg == CVT_IDX_LAST);
	cov_trim_read: cover property (@(posedge aclk) disable iff (!aresetn)
		do_read && rd_index == CVT_OFS_GAIN_A[9:0]);
	cov_slverr: cover property (@(posedge aclk) disable iff (!aresetn)
		rvalid_reg && rresp_reg == CVT_RESP_SLVERR);
endmodule
`default_nettype wire
